// *** rtl/ol_sense_ctrl.sv ***
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module ol_sense_ctrl (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic [1:0] CH_ON,
	input wire logic [15:0] LOAD0_MA,
	input wire logic [15:0] LOAD1_MA,
	input wire logic [15:0] TEMP_CODE,
	input wire logic [15:0] RAND_OFFSET,
	input wire logic OC_WINDOW,
	output logic fault_pin_n,
	output logic sense_valid_pin_alt,
	output logic [15:0] SENSE_OUT,
	output logic LOW_OC_THRESH
);
	// ==========================================================
	// Reset release and pin synchronisers
	logic rst_meta_ff;
	logic rst_ff;
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rst_meta_ff <= 1'b0;
			rst_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_ff <= rst_meta_ff;
		end
	end
	logic [1:0] on_s;
	logic oc_s;
	ol_sync2 #(.W(3)) u_sync (
		.clk(CLK),
		.rst_n(rst_ff),
		.d({OC_WINDOW, CH_ON}),
		.q({oc_s, on_s})
	);
	// Load, temperature and offset pins come from outside the clock domain too
	// These words are treated as quasi-static: a word that changes while it is
	// being sampled may show mixed bits for one cycle before it settles
	logic [15:0] load0_s;
	logic [15:0] load1_s;
	logic [15:0] temp_s;
	logic [15:0] roff_s;
	ol_sync2 #(.W(64)) u_sync_data (
		.clk(CLK),
		.rst_n(rst_ff),
		.d({LOAD0_MA, LOAD1_MA, TEMP_CODE, RAND_OFFSET}),
		.q({load0_s, load1_s, temp_s, roff_s})
	);
	// ==========================================================
	// Configuration registers
	logic [15:0] general_config_register_ff;
	logic [15:0] overcurrent_config_register_ff;
	logic [15:0] channel_config_register_ff [2];
	logic [15:0] retry_register_ff [2];
	wire wr_gen = WR && ADDR == ol_sense_pkg::ADDR_GENERAL_CONFIG;
	wire wr_oc = WR && ADDR == ol_sense_pkg::ADDR_OVERCURRENT_CONFIG;
	wire wr_cfg = WR && ADDR == ol_sense_pkg::ADDR_CHANNEL_CONFIG;
	wire wr_rty = WR && ADDR == ol_sense_pkg::ADDR_RETRY;
	wire fault_rd = RD && ADDR == ol_sense_pkg::ADDR_FAULT;
	wire wsel = WDATA[15];
	// Register writes; bit 15 picks channel for per-channel registers
	always_ff @(posedge CLK or negedge rst_ff)
	begin
		if (!rst_ff)
		begin
			general_config_register_ff <= ol_sense_pkg::GENERAL_CONFIG_RST;
			overcurrent_config_register_ff <= ol_sense_pkg::OVERCURRENT_CONFIG_RST;
			channel_config_register_ff[0] <= ol_sense_pkg::CHANNEL_CONFIG_RST;
			channel_config_register_ff[1] <= ol_sense_pkg::CHANNEL_CONFIG_RST;
			retry_register_ff[0] <= ol_sense_pkg::RETRY_RST;
			retry_register_ff[1] <= ol_sense_pkg::RETRY_RST;
		end
		else
		begin
			if (wr_gen)
				general_config_register_ff <= WDATA;
			if (wr_oc)
				overcurrent_config_register_ff <= WDATA;
			if (wr_cfg)
				channel_config_register_ff[wsel] <= {1'b0, WDATA[14:0]};
			if (wr_rty)
				retry_register_ff[wsel] <= {1'b0, WDATA[14:0]};
		end
	end
	wire low_ratio = overcurrent_config_register_ff[ol_sense_pkg::RATIO_BIT];
	wire track_hold = general_config_register_ff[ol_sense_pkg::TRACK_HOLD_BIT];
	// ==========================================================
	// Open-load detectors
	logic [1:0] flag;
	logic [1:0] live;
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_ch
			ol_channel u_ch (
				.clk(CLK),
				.rst_n(rst_ff),
				.on(on_s[g]),
				.load_ma(g == 0 ? load0_s : load1_s),
				.low_ratio(low_ratio),
				.slew_fast(channel_config_register_ff[g][ol_sense_pkg::SLEW_FAST_BIT]),
				.use_int_pwm(channel_config_register_ff[g][ol_sense_pkg::INT_PWM_BIT]),
				.dir_dis(channel_config_register_ff[g][ol_sense_pkg::DIR_DIS_BIT]),
				.fault_rd(fault_rd),
				.flag_ff(flag[g]),
				.fault_live_ff(live[g])
			);
		end
	endgenerate
	// ==========================================================
	// Sense source selection
	wire [1:0] sel_code = {general_config_register_ff[ol_sense_pkg::SENSE_SEL1_BIT],
		general_config_register_ff[ol_sense_pkg::SENSE_SEL0_BIT]};
	ol_sense_pkg::sense_src_t src;
	assign src = ol_sense_pkg::sense_src_t'(sel_code);
	wire src_ch = src == ol_sense_pkg::SRC_CH1;
	wire src_is_ch = src == ol_sense_pkg::SRC_CH0 || src == ol_sense_pkg::SRC_CH1;
	wire ch_on = on_s[src_ch];
	wire [15:0] ch_load = src_ch ? load1_s : load0_s;
	wire pol = retry_register_ff[src_ch][ol_sense_pkg::OFFSET_POL_BIT];
	// Offset sum wraps at 16 bits on purpose; the sense word has no carry
	wire [15:0] live_sense = pol ? 16'(ch_load + roff_s) : 16'(ch_load - roff_s);
	// ==========================================================
	// Sense state machine
	// Sync pin is low only in the valid state, so an overcurrent window forces the machine back to off at once from any state, and
	// a source change does too, except from hold with the new channel on, which goes to settle
	ol_sense_pkg::sense_state_t state_ff;
	ol_sense_pkg::sense_state_t nxt_state;
	logic [7:0] settle_ff;
	logic [15:0] hold_ff;
	logic src_d_ff;
	wire moved = src_is_ch && src_ch != src_d_ff;
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ol_sense_pkg::SNS_OFF:
				if (ch_on && src_is_ch)
					nxt_state = ol_sense_pkg::SNS_SETTLE;
			ol_sense_pkg::SNS_SETTLE:
				if (!ch_on)
					nxt_state = ol_sense_pkg::SNS_OFF;
				else if (settle_ff >= 8'(ol_sense_pkg::SETTLE_CYC))
					nxt_state = ol_sense_pkg::SNS_VALID;
			ol_sense_pkg::SNS_VALID:
				if (!ch_on)
					nxt_state = track_hold ? ol_sense_pkg::SNS_HOLD
						: ol_sense_pkg::SNS_OFF;
			ol_sense_pkg::SNS_HOLD:
				if (ch_on)
					nxt_state = ol_sense_pkg::SNS_SETTLE;
				else if (moved || !track_hold)
					nxt_state = ol_sense_pkg::SNS_OFF;
			default:
				nxt_state = ol_sense_pkg::SNS_OFF;
		endcase
		if (oc_s || !src_is_ch || (moved && state_ff != ol_sense_pkg::SNS_HOLD))
			nxt_state = ol_sense_pkg::SNS_OFF;
	end
	// State, settle count and sample taken with polarity of on-period
	always_ff @(posedge CLK or negedge rst_ff)
	begin
		if (!rst_ff)
		begin
			state_ff <= ol_sense_pkg::SNS_OFF;
			settle_ff <= 8'h00;
			hold_ff <= 16'h0000;
			src_d_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			src_d_ff <= src_ch;
			settle_ff <= (state_ff == ol_sense_pkg::SNS_SETTLE) ? settle_ff + 8'h01 : 8'h00;
			if (ch_on && state_ff == ol_sense_pkg::SNS_VALID)
				hold_ff <= live_sense;
		end
	end
	// ==========================================================
	// Outputs and read port
	logic [15:0] nxt_rdata;
	always_comb
	begin
		case (ADDR)
			ol_sense_pkg::ADDR_GENERAL_CONFIG: nxt_rdata = general_config_register_ff;
			ol_sense_pkg::ADDR_OVERCURRENT_CONFIG: nxt_rdata = overcurrent_config_register_ff;
			ol_sense_pkg::ADDR_CHANNEL_CONFIG: nxt_rdata = channel_config_register_ff[0];
			ol_sense_pkg::ADDR_RETRY: nxt_rdata = retry_register_ff[0];
			ol_sense_pkg::ADDR_FAULT: nxt_rdata = {14'h0000, flag};
			ol_sense_pkg::ADDR_STATUS: nxt_rdata = {12'h000, live, on_s};
			default: nxt_rdata = 16'h0000;
		endcase
	end
	always_ff @(posedge CLK or negedge rst_ff)
	begin
		if (!rst_ff)
		begin
			RDATA <= 16'h0000;
			fault_pin_n <= 1'b1;
			sense_valid_pin_alt <= 1'b1;
			SENSE_OUT <= 16'h0000;
			LOW_OC_THRESH <= 1'b0;
		end
		else
		begin
			RDATA <= RD ? nxt_rdata : 16'h0000;
			fault_pin_n <= ~|live;
			sense_valid_pin_alt <= !(nxt_state == ol_sense_pkg::SNS_VALID);
			LOW_OC_THRESH <= low_ratio;
			if (src == ol_sense_pkg::SRC_TEMP && !oc_s)
				SENSE_OUT <= temp_s;
			else if (nxt_state == ol_sense_pkg::SNS_VALID)
				SENSE_OUT <= live_sense;
			else if (nxt_state == ol_sense_pkg::SNS_HOLD)
				SENSE_OUT <= hold_ff;
			else
				SENSE_OUT <= 16'h0000;
		end
	end
endmodule : ol_sense_ctrl

// *** shared/ol_sense_pkg.sv ***
package ol_sense_pkg;
	// ==========================================================
	// Register map (word indices, read data one cycle later)
	localparam logic [3:0] ADDR_GENERAL_CONFIG = 4'h0;
	localparam logic [3:0] ADDR_OVERCURRENT_CONFIG = 4'h1;
	localparam logic [3:0] ADDR_CHANNEL_CONFIG = 4'h2;
	localparam logic [3:0] ADDR_RETRY = 4'h3;
	localparam logic [3:0] ADDR_FAULT = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h5;
	// ==========================================================
	// Field positions
	localparam int SENSE_SEL0_BIT = 0;
	localparam int SENSE_SEL1_BIT = 1;
	localparam int TRACK_HOLD_BIT = 2;
	localparam int RATIO_BIT = 0;
	localparam int SLEW_FAST_BIT = 1;
	localparam int DIR_DIS_BIT = 5;
	localparam int INT_PWM_BIT = 6;
	localparam int OFFSET_POL_BIT = 8;
	// ==========================================================
	// Reset values
	localparam logic [15:0] GENERAL_CONFIG_RST = 16'h0000;
	localparam logic [15:0] OVERCURRENT_CONFIG_RST = 16'h0000;
	localparam logic [15:0] CHANNEL_CONFIG_RST = 16'h0000;
	localparam logic [15:0] RETRY_RST = 16'h0000;
	// ==========================================================
	// Open-load thresholds in mA per ratio
	localparam logic [15:0] OL_THRESH_HIGH_MA = 16'd300;
	localparam logic [15:0] OL_THRESH_LOW_MA = 16'd7;
	// ==========================================================
	// Timing
	localparam longint CLK_HZ = 200000000;
	localparam longint OL_PERIOD_MS = 150;
	localparam longint OL_PERIOD_CYC = (OL_PERIOD_MS * CLK_HZ) / 1000;
	localparam int SETTLE_NS = 100;
	localparam int SETTLE_CYC = (SETTLE_NS * 200 + 999) / 1000;
	// ==========================================================
	// Sense source codes
	typedef enum logic [1:0]
	{
		SRC_NONE = 2'b00,
		SRC_CH0 = 2'b01,
		SRC_CH1 = 2'b10,
		SRC_TEMP = 2'b11
	} sense_src_t;
	typedef enum logic [1:0]
	{
		SNS_OFF = 2'b00,
		SNS_SETTLE = 2'b01,
		SNS_VALID = 2'b10,
		SNS_HOLD = 2'b11
	} sense_state_t;
endpackage : ol_sense_pkg

// *** rtl/ol_sync2.sv ***
`timescale 1ns/100ps
// ==========================================================
// Two-stage synchroniser for pin inputs
module ol_sync2 #(
	parameter int W = 1
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;
	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_ff <= '0;
			q <= '0;
		end
		else
		begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule : ol_sync2

// *** rtl/ol_channel.sv ***
`timescale 1ns/100ps
// ==========================================================
// Per-channel on-state open-load detection and flag
module ol_channel (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic on,
	input wire logic [15:0] load_ma,
	input wire logic low_ratio,
	input wire logic slew_fast,
	input wire logic use_int_pwm,
	input wire logic dir_dis,
	input wire logic fault_rd,
	output logic flag_ff,
	output logic fault_live_ff
);
	logic on_d_ff;
	logic [31:0] period_ff;
	logic checked_ok_ff;
	logic [31:0] nxt_period;
	wire turn_off = on_d_ff && !on;
	wire [15:0] thresh = low_ratio ? ol_sense_pkg::OL_THRESH_LOW_MA
		: ol_sense_pkg::OL_THRESH_HIGH_MA;
	wire below = load_ma < thresh;
	wire period_done = period_ff >= 32'(ol_sense_pkg::OL_PERIOD_CYC);
	// Low ratio: modulator checks at first on cycle after period, which at full duty is as soon as due
	wire int_mode = use_int_pwm || dir_dis;
	wire low_check = low_ratio && slew_fast && (int_mode ? (period_done && (turn_off
		|| on)) : turn_off);
	wire high_check = !low_ratio && on;
	wire check = high_check || low_check;
	wire fault_now = check && below;
	wire cause_gone = !below;
	// High ratio clears off-state or once cause gone; low ratio after good check
	wire clr = fault_rd && (low_ratio ? checked_ok_ff
		: (!on || cause_gone));
	assign nxt_period = low_check ? 32'h00000000 : period_ff + 32'h00000001;
	// Period counter, saturating
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			period_ff <= 32'h00000000;
		else if (low_check || !period_done)
			period_ff <= nxt_period;
	end
	// Flag sets over clear; live fault follows detection
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			on_d_ff <= 1'b0;
			flag_ff <= 1'b0;
			fault_live_ff <= 1'b0;
			checked_ok_ff <= 1'b0;
		end
		else
		begin
			on_d_ff <= on;
			if (fault_now)
				flag_ff <= 1'b1;
			else if (clr)
				flag_ff <= 1'b0;
			if (fault_now)
				fault_live_ff <= 1'b1;
			else if ((check && cause_gone) || !on)
				fault_live_ff <= 1'b0;
			if (check)
				checked_ok_ff <= cause_gone;
			else if (fault_rd)
				checked_ok_ff <= 1'b0;
		end
	end
endmodule : ol_channel

// *** dv/ol_sense_chk_sva.sv ***
`timescale 1ns/100ps
// ==========================================================
// Port checker for the open-load and sense block
module ol_sense_chk (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	input wire logic [1:0] CH_ON,
	input wire logic [15:0] LOAD0_MA,
	input wire logic [15:0] LOAD1_MA,
	input wire logic OC_WINDOW,
	input wire logic fault_pin_n,
	input wire logic sense_valid_pin_alt,
	input wire logic LOW_OC_THRESH
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	// Pins tied to their causes
	AST_OC_SYNC: assert property (OC_WINDOW [*5] |-> sense_valid_pin_alt)
		else $error("sync pin low in overcurrent window");
	AST_RATIO: assert property (WR && ADDR == ol_sense_pkg::ADDR_OVERCURRENT_CONFIG
		|-> ##2 LOW_OC_THRESH == $past(WDATA[0], 2)) else $error("threshold level wrong");
	AST_SETTLE: assert property (!sense_valid_pin_alt |-> $past(|CH_ON, 20))
		else $error("sync pin low before settling");
	AST_SYNC_OFF: assert property ((CH_ON == 2'b00) [*8] |-> sense_valid_pin_alt)
		else $error("sync pin low while off");
	AST_OL_SET: assert property ((!LOW_OC_THRESH && CH_ON[0]
		&& LOAD0_MA < ol_sense_pkg::OL_THRESH_HIGH_MA) [*6] |-> !fault_pin_n)
		else $error("open load not flagged");
	AST_OL_GONE: assert property ((!LOW_OC_THRESH && CH_ON == 2'b11 && LOAD0_MA >= 16'd300
		&& LOAD1_MA >= 16'd300) [*6] |-> fault_pin_n) else $error("fault pin stuck low");
	AST_PERIODIC: assert property ($fell(fault_pin_n) && LOW_OC_THRESH
		&& $past(LOW_OC_THRESH, 6) |-> CH_ON != $past(CH_ON, 8))
		else $error("low ratio check while steady");
	AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 16'h0000)
		else $error("read data outside read slot");
	// Main scenarios reached
	cover property (!fault_pin_n);
	cover property (!sense_valid_pin_alt);
	cover property (LOW_OC_THRESH && $fell(fault_pin_n));
endmodule : ol_sense_chk

bind ol_sense_ctrl ol_sense_chk ol_sense_chk_i (.CLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
	.CH_ON, .LOAD0_MA, .LOAD1_MA, .OC_WINDOW, .fault_pin_n, .sense_valid_pin_alt, .LOW_OC_THRESH);

// *** dv/ol_load_model.sv ***
`timescale 1ns/100ps
// ==========================================================
// Switched load: current flows while on, with a short tail after turn-off
module ol_load_model #(
	parameter int DECAY = 8
)(
	input wire logic clk,
	input wire logic on,
	input wire logic [15:0] set_ma,
	output logic [15:0] load_ma
);
	int off_cnt = 0;
	// Cycles since switch-off
	always @(posedge clk)
		off_cnt <= on ? 0 : off_cnt + 1;
	// Inductive tail, then no current at all
	assign load_ma = (on || off_cnt < DECAY) ? set_ma : 16'h0000;
endmodule : ol_load_model

// *** dv/test_ol_sense_ctrl.sv ***
`timescale 1ns/100ps
// ==========================================================
// Bench for the open-load and sense block
module test_ol_sense_ctrl;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, oc_win = 1'b0;
	logic fpin_n, sync_pin, low_oc;
	logic [3:0] addr = 4'h0;
	logic [1:0] ch_on = 2'b00;
	logic [15:0] wdata = 16'h0000, set0 = 16'h0000, set1 = 16'h0000, roff = 16'h0400;
	logic [15:0] rdata, ld0, ld1, sense, s, d;
	int n_mismatch = 0;
	int check_count = 0;
	// Device and its two loads
	ol_sense_ctrl ol_sense_ctrl_i (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .CH_ON(ch_on), .LOAD0_MA(ld0), .LOAD1_MA(ld1),
		.TEMP_CODE(16'h0ABC), .RAND_OFFSET(roff), .OC_WINDOW(oc_win), .fault_pin_n(fpin_n),
		.sense_valid_pin_alt(sync_pin), .SENSE_OUT(sense), .LOW_OC_THRESH(low_oc));
	ol_load_model load0_i (.clk(clk), .on(ch_on[0]), .set_ma(set0), .load_ma(ld0));
	ol_load_model load1_i (.clk(clk), .on(ch_on[1]), .set_ma(set1), .load_ma(ld1));
	// ==========================================================
	// Bus and helper tasks
	initial
		forever #2.5 clk = ~clk;
	task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : bus_rd
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", n, e, g);
			n_mismatch++;
		end
	endtask : chk
	task automatic rdf(input logic [15:0] e);
		bus_rd(ol_sense_pkg::ADDR_FAULT);
		chk("fault flags", e, d);
	endtask : rdf
	// Set channels and loads, then let n cycles pass
	task automatic go(input logic [1:0] on, input logic [15:0] a, input logic [15:0] b, int n);
		@(posedge clk);
		ch_on <= on;
		set0 <= a;
		set1 <= b;
		repeat (n) @(posedge clk);
		#1;
	endtask : go
	task automatic wsync(input logic v);
		for (int i = 0; i < 200 && sync_pin !== v; i++) @(posedge clk) #1;
		chk("sync wait", {15'h0, v}, {15'h0, sync_pin});
	endtask : wsync
	task final_report;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	// ==========================================================
	// Scenarios
	task automatic t_high;
		go(2'b11, 16'd300, 16'd500, 10);
		chk("pin at limit", 16'h0001, {15'h0, fpin_n});
		rdf(16'h0000);
		go(2'b11, 16'd299, 16'd500, 10);
		chk("pin below limit", 16'h0000, {15'h0, fpin_n});
		rdf(16'h0001);
		rdf(16'h0001);
		go(2'b11, 16'd400, 16'd500, 10);
		chk("pin released", 16'h0001, {15'h0, fpin_n});
		rdf(16'h0001);
		rdf(16'h0000);
		go(2'b11, 16'd100, 16'd500, 10);
		go(2'b00, 16'd100, 16'd500, 20);
		rdf(16'h0001);
		rdf(16'h0000);
		$display("t_high done");
	endtask : t_high
	task automatic t_low;
		bus_wr(ol_sense_pkg::ADDR_OVERCURRENT_CONFIG, 16'h0001);
		go(2'b00, 16'd6, 16'd0, 4);
		chk("low threshold", 16'h0001, {15'h0, low_oc});
		go(2'b01, 16'd6, 16'd0, 30);
		go(2'b00, 16'd6, 16'd0, 20);
		rdf(16'h0000);
		bus_wr(ol_sense_pkg::ADDR_CHANNEL_CONFIG, 16'h0002);
		go(2'b01, 16'd6, 16'd0, 30);
		chk("pin while on", 16'h0001, {15'h0, fpin_n});
		go(2'b00, 16'd6, 16'd0, 20);
		rdf(16'h0001);
		rdf(16'h0001);
		go(2'b01, 16'd7, 16'd0, 30);
		go(2'b00, 16'd7, 16'd0, 20);
		rdf(16'h0001);
		rdf(16'h0000);
		// Full duty left on direct input, so no check is wanted
		go(2'b01, 16'd6, 16'd0, 60);
		rdf(16'h0000);
		go(2'b01, 16'd50, 16'd0, 2);
		go(2'b00, 16'd50, 16'd0, 20);
		bus_wr(ol_sense_pkg::ADDR_OVERCURRENT_CONFIG, 16'h0000);
		$display("t_low done");
	endtask : t_low
	task automatic t_sense;
		bus_wr(ol_sense_pkg::ADDR_GENERAL_CONFIG, 16'h0003);
		go(2'b00, 16'h8000, 16'd200, 5);
		chk("temperature", 16'h0ABC, sense);
		bus_wr(ol_sense_pkg::ADDR_GENERAL_CONFIG, 16'h0000);
		go(2'b00, 16'h8000, 16'd200, 5);
		chk("no source", 16'h0000, sense);
		bus_wr(ol_sense_pkg::ADDR_GENERAL_CONFIG, 16'h0001);
		bus_wr(ol_sense_pkg::ADDR_RETRY, 16'h0100);
		go(2'b11, 16'h8000, 16'd200, 2);
		wsync(1'b0);
		go(2'b11, 16'h8000, 16'd200, 10);
		s = sense;
		bus_wr(ol_sense_pkg::ADDR_RETRY, 16'h0000);
		go(2'b11, 16'h8000, 16'd200, 30);
		chk("offset sign", 16'h0001, {15'h0, s > sense});
		bus_wr(ol_sense_pkg::ADDR_GENERAL_CONFIG, 16'h0002);
		go(2'b11, 16'h8000, 16'd200, 30);
		chk("channel choice", 16'h0001, {15'h0, sense !== s});
		@(posedge clk) oc_win <= 1'b1;
		go(2'b11, 16'h8000, 16'd200, 8);
		chk("sync in window", 16'h0001, {15'h0, sync_pin});
		@(posedge clk) oc_win <= 1'b0;
		bus_wr(ol_sense_pkg::ADDR_GENERAL_CONFIG, 16'h0001);
		go(2'b00, 16'h8000, 16'd200, 10);
		chk("sense after off", 16'h0000, sense);
		$display("t_sense done");
	endtask : t_sense
	task automatic t_hold;
		// Hold mode with steady on-periods, never slow switching
		bus_wr(ol_sense_pkg::ADDR_GENERAL_CONFIG, 16'h0005);
		go(2'b01, 16'h8000, 16'd0, 2);
		wsync(1'b0);
		go(2'b01, 16'h8000, 16'd0, 10);
		s = sense;
		go(2'b00, 16'h8000, 16'd0, 20);
		chk("sync when off", 16'h0001, {15'h0, sync_pin});
		chk("held value", s, sense);
		bus_wr(ol_sense_pkg::ADDR_RETRY, 16'h0100);
		go(2'b00, 16'h8000, 16'd0, 5);
		chk("held after sign", s, sense);
		bus_wr(ol_sense_pkg::ADDR_GENERAL_CONFIG, 16'h0006);
		bus_wr(ol_sense_pkg::ADDR_GENERAL_CONFIG, 16'h0005);
		go(2'b00, 16'h8000, 16'd0, 10);
		chk("held lost", 16'h0001, {15'h0, sense !== s});
		$display("t_hold done");
	endtask : t_hold
	// ==========================================================
	// Main sequence and hang guard
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		bus_rd(ol_sense_pkg::ADDR_GENERAL_CONFIG);
		chk("general reset", ol_sense_pkg::GENERAL_CONFIG_RST, d);
		bus_rd(4'hF);
		chk("unmapped", 16'h0000, d);
		t_high();
		t_low();
		t_sense();
		t_hold();
		final_report();
	end
	initial
	begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		final_report();
	end
endmodule : test_ol_sense_ctrl
